// file: shared/amd_pkg.sv
// constants and types for the alarm mask and output divider registers
`default_nettype none
package amd_pkg;

    // register offsets
    localparam logic [7:0] ALARM_INTERRUPT_MASK_OFS          = 8'h18;
    localparam logic [7:0] SHARED_HIGH_SPEED_OUT_DIVIDER_OFS = 8'h19;
    localparam logic [7:0] OUT1_DIVIDER_TOP_BITS_OFS         = 8'h1f;
    localparam logic [7:0] OUT1_DIVIDER_MIDDLE_BYTE_OFS      = 8'h20;
    localparam logic [7:0] OUT1_DIVIDER_LOW_BYTE_OFS         = 8'h21;
    localparam logic [7:0] OUT2_DIVIDER_TOP_BITS_OFS         = 8'h22;

    // reset values
    localparam logic [7:0] ALARM_INTERRUPT_MASK_RST          = 8'h3f;
    localparam logic [7:0] SHARED_HIGH_SPEED_OUT_DIVIDER_RST = 8'h20;
    localparam logic [7:0] OUT1_DIVIDER_TOP_BITS_RST         = 8'h00;
    localparam logic [7:0] OUT1_DIVIDER_MIDDLE_BYTE_RST      = 8'h00;
    localparam logic [7:0] OUT1_DIVIDER_LOW_BYTE_RST         = 8'h31;
    localparam logic [7:0] OUT2_DIVIDER_TOP_BITS_RST         = 8'h00;

    // field positions
    localparam int SECOND_FREQ_OFFSET_MASK_BIT = 2;
    localparam int FIRST_FREQ_OFFSET_MASK_BIT  = 1;
    localparam int LOCK_LOSS_MASK_BIT          = 0;
    localparam int MASK_FIELD_WIDTH            = 3;
    localparam int HS_DIV_LSB                  = 5;
    localparam int HS_DIV_WIDTH                = 3;
    localparam int LS_TOP_WIDTH                = 4;
    localparam int LS_DIV_WIDTH                = 20;

    // high-speed ratio for code 000, ratio rises by one per code
    localparam logic [3:0] HS_RATIO_BASE       = 4'h4;
    localparam logic [2:0] HS_CODE_NO_SKEW     = 3'h0;

    // held alarm flags from the alarm flag registers
    typedef struct packed {
        logic second_freq_offset_flag;
        logic first_freq_offset_flag;
        logic lock_loss_flag;
    } amd_alarm_t;

    // divider settings handed to the output clock path
    typedef struct packed {
        logic [2:0]  shared_high_speed_divider;
        logic [3:0]  high_speed_ratio;
        logic [19:0] out1_low_speed_divider;
        logic [3:0]  out2_low_speed_divider_top;
    } amd_divider_t;

endpackage : amd_pkg
`default_nettype wire

// file: rtl/amd_regs.sv
// alarm mask and output divider register slice
`default_nettype none
module amd_regs (
    // clock and reset
    input  wire logic              clk_in,
    input  wire logic              sys_rst_in,
    // register port from the serial configuration engine
    input  wire logic [7:0]        reg_addr_in,
    input  wire logic              reg_wr_in,
    input  wire logic [7:0]        reg_wdata_in,
    input  wire logic              reg_rd_in,
    output var  logic [7:0]        reg_rdata_out,
    output var  logic              reg_rvalid_out,
    // held alarm flags and pin routing controls
    input  wire amd_pkg::amd_alarm_t alarm_flags_in,
    input  wire logic              interrupt_routing_in,
    input  wire logic              interrupt_polarity_in,
    input  wire logic              input_bad_pin_enable_in,
    input  wire logic              input_bad_polarity_in,
    input  wire logic              first_input_bad_in,
    // coarse skew requests
    input  wire logic              skew_inc_pin_in,
    input  wire logic              skew_dec_pin_in,
    input  wire logic              skew_reg_step_in,
    input  wire logic              skew_reg_dir_in,
    // pin, pending, skew and divider outputs
    output var  logic              interrupt_or_input_bad_pin_out,
    output var  logic              interrupt_or_input_bad_pin_oe_out,
    output var  logic              interrupt_pending_out,
    output var  logic              skew_step_out,
    output var  logic              skew_dir_out,
    output var  amd_pkg::amd_divider_t divider_out
);

    logic [2:0] alarm_mask;
    logic [2:0] shared_high_speed_divider;
    logic [3:0] out1_top;
    logic [7:0] out1_middle;
    logic [7:0] out1_low;
    logic [3:0] out2_top;
    logic       next_irq;
    logic       next_pin;
    logic       next_oe;
    logic       skew_req;
    logic       skew_dir;

    function automatic logic [3:0] hs_ratio(input logic [2:0] code);
        hs_ratio = amd_pkg::HS_RATIO_BASE + {1'b0, code};
    endfunction

    // one strobe compare shared by the mask and high-speed divider processes
    function automatic logic wr_hit(input logic wr, input logic [7:0] addr,
                                    input logic [7:0] ofs);
        wr_hit = wr && addr == ofs;
    endfunction

    // mask register; flags are inputs held elsewhere, so a write cannot touch them
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            alarm_mask <= amd_pkg::ALARM_INTERRUPT_MASK_RST[2:0];
        end
        else if (wr_hit(reg_wr_in, reg_addr_in, amd_pkg::ALARM_INTERRUPT_MASK_OFS))
        begin
            alarm_mask <= reg_wdata_in[2:0];
        end
    end

    // shared high-speed divider; low five bits are not stored
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            shared_high_speed_divider <=
                amd_pkg::SHARED_HIGH_SPEED_OUT_DIVIDER_RST[7:5];
        end
        else if (wr_hit(reg_wr_in, reg_addr_in, amd_pkg::SHARED_HIGH_SPEED_OUT_DIVIDER_OFS))
        begin
            shared_high_speed_divider <= reg_wdata_in[7:5];
        end
    end

    // low-speed dividers; even codes are the host's to avoid, stored as written
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            out1_top    <= amd_pkg::OUT1_DIVIDER_TOP_BITS_RST[3:0];
            out1_middle <= amd_pkg::OUT1_DIVIDER_MIDDLE_BYTE_RST;
            out1_low    <= amd_pkg::OUT1_DIVIDER_LOW_BYTE_RST;
            out2_top    <= amd_pkg::OUT2_DIVIDER_TOP_BITS_RST[3:0];
        end
        else if (reg_wr_in)
        begin
            case (reg_addr_in)
                amd_pkg::OUT1_DIVIDER_TOP_BITS_OFS:    out1_top    <= reg_wdata_in[3:0];
                amd_pkg::OUT1_DIVIDER_MIDDLE_BYTE_OFS: out1_middle <= reg_wdata_in;
                amd_pkg::OUT1_DIVIDER_LOW_BYTE_OFS:    out1_low    <= reg_wdata_in;
                amd_pkg::OUT2_DIVIDER_TOP_BITS_OFS:    out2_top    <= reg_wdata_in[3:0];
                default:                               out2_top    <= out2_top;
            endcase
        end
    end

    // read path, one cycle latency; unmapped addresses read zero
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            reg_rdata_out  <= 8'h00;
            reg_rvalid_out <= 1'b0;
        end
        else
        begin
            reg_rvalid_out <= reg_rd_in;
            if (reg_rd_in)
            begin
                case (reg_addr_in)
                    amd_pkg::ALARM_INTERRUPT_MASK_OFS:
                        reg_rdata_out <= {amd_pkg::ALARM_INTERRUPT_MASK_RST[7:3],
                                          alarm_mask};
                    amd_pkg::SHARED_HIGH_SPEED_OUT_DIVIDER_OFS:
                        reg_rdata_out <= {
                            shared_high_speed_divider,
                            amd_pkg::SHARED_HIGH_SPEED_OUT_DIVIDER_RST[4:0]
                        };
                    amd_pkg::OUT1_DIVIDER_TOP_BITS_OFS:
                        reg_rdata_out <= {amd_pkg::OUT1_DIVIDER_TOP_BITS_RST[7:4], out1_top};
                    amd_pkg::OUT1_DIVIDER_MIDDLE_BYTE_OFS:
                        reg_rdata_out <= out1_middle;
                    amd_pkg::OUT1_DIVIDER_LOW_BYTE_OFS:
                        reg_rdata_out <= out1_low;
                    amd_pkg::OUT2_DIVIDER_TOP_BITS_OFS:
                        reg_rdata_out <= {amd_pkg::OUT2_DIVIDER_TOP_BITS_RST[7:4], out2_top};
                    default:
                        reg_rdata_out <= 8'h00;
                endcase
            end
        end
    end

    // interrupt condition and pin function
    // pending ignores routing, so software can poll it while the pin shows input-bad
    always_comb
    begin
        next_irq = (alarm_flags_in.second_freq_offset_flag
                    & ~alarm_mask[amd_pkg::SECOND_FREQ_OFFSET_MASK_BIT])
                 | (alarm_flags_in.first_freq_offset_flag
                    & ~alarm_mask[amd_pkg::FIRST_FREQ_OFFSET_MASK_BIT])
                 | (alarm_flags_in.lock_loss_flag
                    & ~alarm_mask[amd_pkg::LOCK_LOSS_MASK_BIT]);
        if (interrupt_routing_in)
        begin
            next_pin = interrupt_polarity_in ? next_irq : ~next_irq;
            next_oe  = 1'b1;
        end
        else
        begin
            next_pin = input_bad_polarity_in ? first_input_bad_in : ~first_input_bad_in;
            next_oe  = input_bad_pin_enable_in;
        end
    end

    // pin is registered, so it trails the flags by one cycle
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            interrupt_pending_out             <= 1'b0;
            interrupt_or_input_bad_pin_out    <= 1'b0;
            interrupt_or_input_bad_pin_oe_out <= 1'b0;
        end
        else
        begin
            interrupt_pending_out             <= next_irq;
            interrupt_or_input_bad_pin_out    <= next_pin;
            interrupt_or_input_bad_pin_oe_out <= next_oe;
        end
    end

    // coarse skew; pin pair wins over register step when both arrive
    always_comb
    begin
        skew_req = skew_inc_pin_in | skew_dec_pin_in | skew_reg_step_in;
        skew_dir = (skew_inc_pin_in | skew_dec_pin_in) ? skew_inc_pin_in : skew_reg_dir_in;
    end

    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            skew_step_out <= 1'b0;
            skew_dir_out  <= 1'b0;
        end
        else
        begin
            // ratio 4 leaves no room for a coarse step
            skew_step_out <= skew_req
                && shared_high_speed_divider != amd_pkg::HS_CODE_NO_SKEW;
            skew_dir_out  <= skew_dir;
        end
    end

    // divider settings toward the clock path
    // zero during reset; stored reset values appear one edge after release
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            divider_out <= '0;
        end
        else
        begin
            divider_out.shared_high_speed_divider  <= shared_high_speed_divider;
            divider_out.high_speed_ratio           <= hs_ratio(shared_high_speed_divider);
            divider_out.out1_low_speed_divider     <= {out1_top, out1_middle, out1_low};
            divider_out.out2_low_speed_divider_top <= out2_top;
        end
    end

endmodule // amd_regs
`default_nettype wire

// file: tb/amd_host.sv
// host model driving the register port of the slice
`default_nettype none
module amd_host (
    // clock
    input  wire logic       clk_in,
    // register port toward the device
    output var  logic [7:0] addr_out,
    output var  logic       wr_out,
    output var  logic [7:0] wdata_out,
    output var  logic       rd_out,
    input  wire logic [7:0] rdata_in,
    input  wire logic       rvalid_in
);
    timeunit 1ns;
    timeprecision 1ns;
    initial {addr_out, wr_out, wdata_out, rd_out} = '0;
    // released lines show the inverse, so a stale value cannot match
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk_in) {addr_out, wdata_out, wr_out} = {a, d, 1'b1};
        @(negedge clk_in) {addr_out, wdata_out, wr_out} = {~a, ~d, 1'b0};
    endtask
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d, output logic v);
        @(negedge clk_in) {addr_out, rd_out} = {a, 1'b1};
        // valid stands for one cycle only, so take the answer while it does
        @(negedge clk_in) {d, v} = {rdata_in, rvalid_in};
        {addr_out, rd_out} = {~a, 1'b0};
    endtask
endmodule // amd_host
`default_nettype wire

// file: tb/amd_regs_asserts.sv
// concurrent checks on the register slice ports
`default_nettype none
module amd_regs_asserts (
    // clock and reset
    input wire logic                  clk_in,
    input wire logic                  sys_rst_in,
    // watched ports
    input wire logic                  reg_rd_in,
    input wire logic                  reg_rvalid_out,
    input wire amd_pkg::amd_alarm_t   alarm_flags_in,
    input wire logic                  interrupt_pending_out,
    input wire logic                  skew_inc_pin_in,
    input wire logic                  skew_dec_pin_in,
    input wire logic                  skew_reg_step_in,
    input wire logic                  skew_step_out,
    input wire amd_pkg::amd_divider_t divider_out
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    wire logic       req  = skew_inc_pin_in | skew_dec_pin_in | skew_reg_step_in;
    // divider_out lags the stored code by one edge, so look one edge on
    wire logic [2:0] code = divider_out.shared_high_speed_divider;
    AST_RVALID: assert property (reg_rd_in |=> reg_rvalid_out)
        else $error("read not answered");
    AST_RVALID_ONE: assert property (!reg_rd_in |=> !reg_rvalid_out)
        else $error("read valid without read");
    AST_NO_FLAG: assert property (alarm_flags_in == 3'h0 |=> !interrupt_pending_out)
        else $error("pending with no flag");
    AST_SKEW_OFF: assert property ((req ##1 code == 3'h0) |-> !skew_step_out)
        else $error("skew step at ratio four");
    AST_SKEW_ON: assert property ((req ##1 code != 3'h0) |-> skew_step_out)
        else $error("skew step lost");
    AST_NO_REQ: assert property (!req |=> !skew_step_out)
        else $error("skew step without request");
    AST_RATIO: assert property (
        !$past(sys_rst_in) |-> divider_out.high_speed_ratio == 4'(code) + 4'h4)
        else $error("ratio does not match code");
    AST_RST_DIV: assert property (
        $fell(sys_rst_in) |=> divider_out == {3'h1, 4'h5, 20'h00031, 4'h0})
        else $error("divider reset value wrong");
endmodule // amd_regs_asserts
bind amd_regs amd_regs_asserts u_asserts (.clk_in(clk_in), .sys_rst_in(sys_rst_in),
    .reg_rd_in(reg_rd_in), .reg_rvalid_out(reg_rvalid_out), .alarm_flags_in(alarm_flags_in),
    .interrupt_pending_out(interrupt_pending_out), .skew_inc_pin_in(skew_inc_pin_in),
    .skew_dec_pin_in(skew_dec_pin_in), .skew_reg_step_in(skew_reg_step_in),
    .skew_step_out(skew_step_out), .divider_out(divider_out));
`default_nettype wire

// file: tb/amd_regs_tb.sv
// random self-checking bench for the register slice
`default_nettype none
module amd_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_in = 1'b0, sys_rst_in = 1'b1;
    logic [7:0] addr, wdata, rdata, d;
    logic wr, rd, rvalid, e, pin, oe, pend, step, dir;
    logic route = 0, pol = 0, bad_en = 0, bad_pol = 0, bad = 0, inc = 0, dec = 0, rstep = 0;
    logic rdir = 0;
    amd_pkg::amd_alarm_t flags = '0;
    amd_pkg::amd_divider_t div;
    logic [7:0] offs [7] = '{8'h18, 8'h19, 8'h1f, 8'h20, 8'h21, 8'h22, 8'h23};
    logic [7:0] rstv [7] = '{8'h3f, 8'h20, 8'h00, 8'h00, 8'h31, 8'h00, 8'h00};
    logic [7:0] last [7];
    int errors = 0, checked = 0, cycles = 0, seed = 31;
    always #50 clk_in = ~clk_in;
    amd_host u_host (.clk_in(clk_in), .addr_out(addr), .wr_out(wr), .wdata_out(wdata),
        .rd_out(rd), .rdata_in(rdata), .rvalid_in(rvalid));
    amd_regs u_dut (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_addr_in(addr),
        .reg_wr_in(wr), .reg_wdata_in(wdata), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .reg_rvalid_out(rvalid), .alarm_flags_in(flags), .interrupt_routing_in(route),
        .interrupt_polarity_in(pol), .input_bad_pin_enable_in(bad_en),
        .input_bad_polarity_in(bad_pol), .first_input_bad_in(bad), .skew_inc_pin_in(inc),
        .skew_dec_pin_in(dec), .skew_reg_step_in(rstep), .skew_reg_dir_in(rdir),
        .interrupt_or_input_bad_pin_out(pin), .interrupt_or_input_bad_pin_oe_out(oe),
        .interrupt_pending_out(pend), .skew_step_out(step), .skew_dir_out(dir),
        .divider_out(div));
    function automatic logic [7:0] exp_rd(input logic [7:0] a, input logic [7:0] v);
        case (a)
            8'h18: return {5'h07, v[2:0]};
            8'h19: return {v[7:5], 5'h00};
            8'h1f, 8'h22: return {4'h0, v[3:0]};
            8'h20, 8'h21: return v;
            default: return 8'h00;
        endcase
    endfunction
    task automatic cmp_val(input logic [19:0] got, input logic [19:0] exp);
        checked++;
        if (got !== exp)
        begin
            errors++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cmp_bit(input logic got, input logic exp);
        cmp_val(20'(got), 20'(exp));
    endtask
    task automatic results(input logic hung);
        if (hung) errors++;
        $display("checked %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic do_reset();
        @(negedge clk_in) sys_rst_in = 1'b1;
        repeat (3) @(negedge clk_in);
        sys_rst_in = 1'b0;
    endtask
    // whole run needs about 135 cycles
    always @(posedge clk_in) if (++cycles == 3000) results(1'b1);
    initial
    begin
        do_reset();
        for (int i = 0; i < 7; i++)
        begin
            u_host.read_reg(offs[i], d, e);
            cmp_bit(e, 1'b1);
            cmp_val(20'(d), 20'(exp_rd(offs[i], rstv[i])));
            last[i] = 8'($random(seed));
            if (i == 4) last[i][0] = 1'b1;
            u_host.write_reg(offs[i], last[i]);
            u_host.read_reg(offs[i], d, e);
            cmp_val(20'(d), 20'(exp_rd(offs[i], last[i])));
        end
        @(negedge clk_in);
        cmp_val(div.out1_low_speed_divider, {last[2][3:0], last[3], last[4]});
        cmp_val(20'(div.out2_low_speed_divider_top), 20'(last[5][3:0]));
        for (int m = 0; m < 8; m++)
        begin
            u_host.write_reg(8'h18, 8'(m));
            {flags, pol, bad_en, bad_pol, bad} = 7'($random(seed));
            route = m[0];
            repeat (3) @(negedge clk_in);
            e = |(flags & ~3'(m));
            cmp_bit(pend, e);
            cmp_bit(oe, route | bad_en);
            if (route | bad_en) cmp_bit(pin, route ? e ~^ pol : bad ~^ bad_pol);
        end
        for (int c = 0; c < 8; c++)
        begin
            u_host.write_reg(8'h19, 8'(c << 5));
            repeat (2) @(negedge clk_in);
            cmp_val(20'(div.high_speed_ratio), 20'(c + 4));
            {inc, dec, rstep} = 3'b100 >> (c % 3);
            rdir = c[2];
            e = inc | (~dec & rdir);
            @(negedge clk_in);
            {inc, dec, rstep} = 3'b000;
            cmp_bit(step, c != 0);
            cmp_bit(dir, e);
        end
        do_reset();
        u_host.read_reg(8'h18, d, e);
        cmp_val(20'(d), 20'h0003f);
        results(1'b0);
    end
endmodule // amd_regs_tb
`default_nettype wire
